// file: pkg/alarm_pkg.sv
// constants, field layouts and register map of the alarm comparison block
// Functional notes
// RULE1 - a field is compared with its time counter only while its enable bit is one
// RULE2 - first joint match of all enabled fields with irq enable sets flag and interrupt
// RULE3 - fields with enable bit zero neither block nor cause an alarm
// RULE4 - bit 7 of each alarm register is the field enable, one enables
// RULE5 - seconds and minutes alarm hold BCD 0 to 59 in bits 6..0
// RULE6 - hours alarm: bit 6 unused, 24h bits 5..0, 12h bit 5 PM and 4..0
// RULE7 - day-of-month alarm holds BCD 1 to 31 in bits 5..0, bit 6 unused
// RULE8 - weekday alarm holds 1 to 7 in bits 2..0, bits 6..3 unused
// RULE9 - year alarm holds BCD 0 to 79 in bits 6..0 and joins the match
// RULE10 - match judged per timekeeping update; flag sets on entry, stays until cleared
package alarm_pkg;

    // ****************************************
    // widths
    // ****************************************
    localparam int ADDR_W     = 8;
    localparam int DATA_W     = 8;
    localparam int FIELD_W    = 7;
    localparam int NUM_FIELDS = 6;

    // ****************************************
    // register offsets
    // ****************************************
    localparam logic [ADDR_W-1:0] ADDR_INT_MASK     = 8'h01;
    localparam logic [ADDR_W-1:0] ADDR_INT_STATUS   = 8'h02;
    localparam logic [ADDR_W-1:0] ADDR_MATCH_STATUS = 8'h03;
    localparam logic [ADDR_W-1:0] ADDR_ALARM_SEC    = 8'h10;
    localparam logic [ADDR_W-1:0] ADDR_ALARM_MIN    = 8'h11;
    localparam logic [ADDR_W-1:0] ADDR_ALARM_HOUR   = 8'h12;
    localparam logic [ADDR_W-1:0] ADDR_ALARM_DAY    = 8'h13;
    localparam logic [ADDR_W-1:0] ADDR_ALARM_WDAY   = 8'h14;
    localparam logic [ADDR_W-1:0] ADDR_ALARM_YEAR   = 8'h16;

    // ****************************************
    // field positions
    // ****************************************
    localparam int ENABLE_BIT    = 7;
    localparam int IRQ_EN_BIT    = 0;
    localparam int FLAG_BIT      = 0;
    localparam int MATCH_BIT     = 0;
    localparam int ANY_EN_BIT    = 1;

    // value bits kept per field; the rest read as zero
    localparam logic [FIELD_W-1:0] SEC_MASK  = 7'h7f;
    localparam logic [FIELD_W-1:0] MIN_MASK  = 7'h7f;
    localparam logic [FIELD_W-1:0] HOUR_MASK = 7'h3f;
    localparam logic [FIELD_W-1:0] DAY_MASK  = 7'h3f;
    localparam logic [FIELD_W-1:0] WDAY_MASK = 7'h07;
    localparam logic [FIELD_W-1:0] YEAR_MASK = 7'h7f;

    // ****************************************
    // reset values
    // ****************************************
    localparam logic [FIELD_W-1:0] FIELD_RESET = 7'h00;
    localparam logic [DATA_W-1:0]  DATA_ZERO   = 8'h00;

    // ****************************************
    // field index
    // ****************************************
    typedef enum logic [2:0] {
        FLD_SEC  = 3'b000,
        FLD_MIN  = 3'b001,
        FLD_HOUR = 3'b010,
        FLD_DAY  = 3'b011,
        FLD_WDAY = 3'b100,
        FLD_YEAR = 3'b101
    } field_e;

endpackage : alarm_pkg

// file: hw/alarm_field_match.sv
// one alarm field compared against its running time counter
module alarm_field_match
    import alarm_pkg::*;
#(
    parameter logic [FIELD_W-1:0] FIELD_MASK = 7'h7f
) (
    input  wire logic [FIELD_W-1:0] alarm_value,
    input  wire logic               field_match_enable,
    input  wire logic [FIELD_W-1:0] current_value,
    output logic                    field_pass
);

    // disabled field always passes so it never blocks the joint match
    always_comb begin
        if (field_match_enable) begin
            field_pass = ((alarm_value & FIELD_MASK) == (current_value & FIELD_MASK)); // RULE1
        end else begin
            field_pass = 1'b1; // RULE3
        end
    end

endmodule : alarm_field_match

// file: hw/rtc_alarm_compare.sv
// alarm registers, joint match, alarm flag and interrupt of the clock/calendar
//
// Our own choice: strobed register access.
module rtc_alarm_compare
    import alarm_pkg::*;
(
    input  wire logic              MCLK,
    input  wire logic              ARST_N,
    input  wire logic [ADDR_W-1:0] ADDR,
    input  wire logic [DATA_W-1:0] WDATA,
    input  wire logic              WR,
    input  wire logic              RD,
    output logic      [DATA_W-1:0] RDATA,
    input  wire logic              TICK,
    input  wire logic [DATA_W-1:0] CUR_SECONDS,
    input  wire logic [DATA_W-1:0] CUR_MINUTES,
    input  wire logic [DATA_W-1:0] CUR_HOURS,
    input  wire logic [DATA_W-1:0] CUR_DAYS,
    input  wire logic [DATA_W-1:0] CUR_WEEKDAYS,
    input  wire logic [DATA_W-1:0] CUR_YEARS,
    output logic                   IRQ,
    output logic                   ALARM_FLAG,
    output logic                   MATCH
);

    // ****************************************
    // functions
    // ****************************************

    // map a register offset to an alarm field; valid low when none
    function automatic logic field_hit(input logic [ADDR_W-1:0] a,
                                       output field_e idx);
        logic hit;
        hit = 1'b1;
        idx = FLD_SEC;
        if (a == ADDR_ALARM_SEC) begin
            idx = FLD_SEC;
        end else if (a == ADDR_ALARM_MIN) begin
            idx = FLD_MIN;
        end else if (a == ADDR_ALARM_HOUR) begin
            idx = FLD_HOUR;
        end else if (a == ADDR_ALARM_DAY) begin
            idx = FLD_DAY;
        end else if (a == ADDR_ALARM_WDAY) begin
            idx = FLD_WDAY;
        end else if (a == ADDR_ALARM_YEAR) begin
            idx = FLD_YEAR;
        end else begin
            hit = 1'b0;
        end
        return hit;
    endfunction : field_hit

    // value bits that a field keeps
    function automatic logic [FIELD_W-1:0] field_mask(input field_e idx);
        logic [FIELD_W-1:0] m;
        m = SEC_MASK;
        case (idx)
            FLD_SEC:  m = SEC_MASK;  // RULE5
            FLD_MIN:  m = MIN_MASK;  // RULE5
            FLD_HOUR: m = HOUR_MASK; // RULE6
            FLD_DAY:  m = DAY_MASK;  // RULE7
            FLD_WDAY: m = WDAY_MASK; // RULE8
            FLD_YEAR: m = YEAR_MASK; // RULE9
            default:  m = SEC_MASK;
        endcase
        return m;
    endfunction : field_mask

    // ****************************************
    // declarations
    // ****************************************
    logic [FIELD_W-1:0] alarm_value_q [NUM_FIELDS];
    logic [NUM_FIELDS-1:0] field_match_enable_q;
    logic [FIELD_W-1:0] current_value [NUM_FIELDS];
    logic [NUM_FIELDS-1:0] field_pass;
    logic                  alarm_irq_enable_q;
    logic                  alarm_flag_q;
    logic                  alarm_flag_d;
    logic                  match_prev_q;
    logic                  irq_q;
    logic [DATA_W-1:0]     rdata_q;
    logic [DATA_W-1:0]     rdata_d;
    logic                  match_now;
    logic                  any_enabled;
    logic                  alarm_rise;
    logic                  wr_field_hit;
    field_e                wr_field_idx;
    logic                  rd_field_hit;
    field_e                rd_field_idx;
    logic                  flag_clear;

    // ****************************************
    // address decode
    // ****************************************

    // field targeted by the current write and read strobes
    always_comb begin
        wr_field_idx = FLD_SEC;
        rd_field_idx = FLD_SEC;
        wr_field_hit = field_hit(ADDR, wr_field_idx);
        rd_field_hit = field_hit(ADDR, rd_field_idx);
    end

    // ****************************************
    // alarm registers
    // ****************************************

    // alarm values, unused bits dropped on write
    always_ff @(posedge MCLK or negedge ARST_N) begin
        if (!ARST_N) begin
            for (int i = 0; i < NUM_FIELDS; i++) begin
                alarm_value_q[i] <= FIELD_RESET;
            end
        end else if (WR && wr_field_hit) begin
            alarm_value_q[wr_field_idx] <= WDATA[FIELD_W-1:0] & field_mask(wr_field_idx);
        end
    end

    // per-field enable bits taken from bit 7
    always_ff @(posedge MCLK or negedge ARST_N) begin
        if (!ARST_N) begin
            field_match_enable_q <= '0;
        end else if (WR && wr_field_hit) begin
            field_match_enable_q[wr_field_idx] <= WDATA[ENABLE_BIT]; // RULE4
        end
    end

    // interrupt mask: the alarm irq enable
    always_ff @(posedge MCLK or negedge ARST_N) begin
        if (!ARST_N) begin
            alarm_irq_enable_q <= 1'b0;
        end else if (WR && ADDR == ADDR_INT_MASK) begin
            alarm_irq_enable_q <= WDATA[IRQ_EN_BIT];
        end
    end

    // ****************************************
    // field comparison
    // ****************************************

    // running counters arranged in field order
    always_comb begin
        current_value[FLD_SEC]  = CUR_SECONDS[FIELD_W-1:0];
        current_value[FLD_MIN]  = CUR_MINUTES[FIELD_W-1:0];
        current_value[FLD_HOUR] = CUR_HOURS[FIELD_W-1:0];
        current_value[FLD_DAY]  = CUR_DAYS[FIELD_W-1:0];
        current_value[FLD_WDAY] = CUR_WEEKDAYS[FIELD_W-1:0];
        current_value[FLD_YEAR] = CUR_YEARS[FIELD_W-1:0];
    end

    // one comparator per field with the field's own bit mask
    alarm_field_match #(.FIELD_MASK(SEC_MASK)) u_match_sec (
        .alarm_value        (alarm_value_q[FLD_SEC]),
        .field_match_enable (field_match_enable_q[FLD_SEC]),
        .current_value      (current_value[FLD_SEC]),
        .field_pass         (field_pass[FLD_SEC])
    );

    alarm_field_match #(.FIELD_MASK(MIN_MASK)) u_match_min (
        .alarm_value        (alarm_value_q[FLD_MIN]),
        .field_match_enable (field_match_enable_q[FLD_MIN]),
        .current_value      (current_value[FLD_MIN]),
        .field_pass         (field_pass[FLD_MIN])
    );

    alarm_field_match #(.FIELD_MASK(HOUR_MASK)) u_match_hour (
        .alarm_value        (alarm_value_q[FLD_HOUR]),
        .field_match_enable (field_match_enable_q[FLD_HOUR]),
        .current_value      (current_value[FLD_HOUR]),
        .field_pass         (field_pass[FLD_HOUR])
    );

    alarm_field_match #(.FIELD_MASK(DAY_MASK)) u_match_day (
        .alarm_value        (alarm_value_q[FLD_DAY]),
        .field_match_enable (field_match_enable_q[FLD_DAY]),
        .current_value      (current_value[FLD_DAY]),
        .field_pass         (field_pass[FLD_DAY])
    );

    alarm_field_match #(.FIELD_MASK(WDAY_MASK)) u_match_wday (
        .alarm_value        (alarm_value_q[FLD_WDAY]),
        .field_match_enable (field_match_enable_q[FLD_WDAY]),
        .current_value      (current_value[FLD_WDAY]),
        .field_pass         (field_pass[FLD_WDAY])
    );

    alarm_field_match #(.FIELD_MASK(YEAR_MASK)) u_match_year (
        .alarm_value        (alarm_value_q[FLD_YEAR]),
        .field_match_enable (field_match_enable_q[FLD_YEAR]),
        .current_value      (current_value[FLD_YEAR]),
        .field_pass         (field_pass[FLD_YEAR])
    );

    // joint match; with no field enabled there is no alarm at all
    assign any_enabled = |field_match_enable_q;
    assign match_now   = any_enabled & (&field_pass); // RULE2

    // ****************************************
    // match edge and alarm flag
    // ****************************************

    // match state sampled once per timekeeping update
    always_ff @(posedge MCLK or negedge ARST_N) begin
        if (!ARST_N) begin
            match_prev_q <= 1'b0;
        end else if (TICK) begin
            match_prev_q <= match_now; // RULE10
        end
    end

    // only the update that enters the matching state counts
    assign alarm_rise = TICK & match_now & ~match_prev_q; // RULE10
    assign flag_clear = WR && (ADDR == ADDR_INT_STATUS) && WDATA[FLAG_BIT];

    // sticky flag, write one to clear; a new alarm wins over the clear
    always_comb begin
        alarm_flag_d = alarm_flag_q;
        if (alarm_rise && alarm_irq_enable_q) begin
            alarm_flag_d = 1'b1; // RULE2
        end else if (flag_clear) begin
            alarm_flag_d = 1'b0; // RULE10
        end
    end

    always_ff @(posedge MCLK or negedge ARST_N) begin
        if (!ARST_N) begin
            alarm_flag_q <= 1'b0;
        end else begin
            alarm_flag_q <= alarm_flag_d;
        end
    end

    // interrupt level while the flag is set and unmasked
    always_ff @(posedge MCLK or negedge ARST_N) begin
        if (!ARST_N) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= alarm_flag_q & alarm_irq_enable_q; // RULE2
        end
    end

    // ****************************************
    // read path
    // ****************************************

    // read data for the cycle after the strobe, zero otherwise
    always_comb begin
        rdata_d = DATA_ZERO;
        if (RD) begin
            if (rd_field_hit) begin
                rdata_d = {field_match_enable_q[rd_field_idx], alarm_value_q[rd_field_idx]};
            end else if (ADDR == ADDR_INT_MASK) begin
                rdata_d[IRQ_EN_BIT] = alarm_irq_enable_q;
            end else if (ADDR == ADDR_INT_STATUS) begin
                rdata_d[FLAG_BIT] = alarm_flag_q;
            end else if (ADDR == ADDR_MATCH_STATUS) begin
                rdata_d[MATCH_BIT]  = match_prev_q;
                rdata_d[ANY_EN_BIT] = any_enabled;
            end else begin
                rdata_d = DATA_ZERO; // unmapped offsets read zero
            end
        end
    end

    always_ff @(posedge MCLK or negedge ARST_N) begin
        if (!ARST_N) begin
            rdata_q <= DATA_ZERO;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    // ****************************************
    // outputs
    // ****************************************
    assign RDATA      = rdata_q;
    assign IRQ        = irq_q;
    assign ALARM_FLAG = alarm_flag_q;
    assign MATCH      = match_prev_q;

endmodule : rtc_alarm_compare

// file: verif/rtc_alarm_compare_asserts.sv
// concurrent checks on the ports of the alarm comparison block
module rtc_alarm_compare_asserts
    import alarm_pkg::*;
(
    input wire logic              MCLK,
    input wire logic              ARST_N,
    input wire logic [ADDR_W-1:0] ADDR,
    input wire logic [DATA_W-1:0] WDATA,
    input wire logic              WR,
    input wire logic              RD,
    input wire logic [DATA_W-1:0] RDATA,
    input wire logic              TICK,
    input wire logic              IRQ,
    input wire logic              ALARM_FLAG,
    input wire logic              MATCH
);
    // ****************************************
    // clocking and helpers
    // ****************************************
    default clocking cb @(posedge MCLK); endclocking
    default disable iff (!ARST_N);
    // software write of one to the flag bit
    wire logic clr_w = WR && ADDR == ADDR_INT_STATUS && WDATA[FLAG_BIT];
    // software write to the mask register
    wire logic msk_w = WR && ADDR == ADDR_INT_MASK;

    // ****************************************
    // properties
    // ****************************************
    a_read_idle_zero: assert property (!RD |=> RDATA == DATA_ZERO)
        else $error("read data not zero outside a read");
    a_flag_on_entry: assert property ($rose(ALARM_FLAG) |-> $past(TICK) && MATCH && !$past(MATCH))
        else $error("alarm flag rose without entry into match");
    a_flag_sticks: assert property (ALARM_FLAG && !clr_w |=> ALARM_FLAG)
        else $error("alarm flag dropped without a clear");
    a_flag_clears: assert property (clr_w && !TICK |=> !ALARM_FLAG)
        else $error("alarm flag not cleared by write");
    a_irq_after_flag: assert property (IRQ |-> $past(ALARM_FLAG))
        else $error("interrupt without flag one cycle before");
    a_irq_drops: assert property (!ALARM_FLAG |=> !IRQ)
        else $error("interrupt stayed after flag fell");
    a_irq_holds: assert property (IRQ && ALARM_FLAG && !$past(msk_w) |=> IRQ)
        else $error("interrupt fell while flag and enable stand");
    a_match_steady: assert property (!TICK |=> $stable(MATCH))
        else $error("match changed without a timekeeping update");
endmodule : rtc_alarm_compare_asserts

bind rtc_alarm_compare rtc_alarm_compare_asserts rtc_alarm_compare_asserts_inst (
    .MCLK(MCLK), .ARST_N(ARST_N), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
    .RDATA(RDATA), .TICK(TICK), .IRQ(IRQ), .ALARM_FLAG(ALARM_FLAG), .MATCH(MATCH)
);

// file: verif/rtc_alarm_compare_bench.sv
// self-checking bench of the alarm comparison block
module rtc_alarm_compare_bench
    import alarm_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic              mclk = 0;
    logic              arst_n = 0;
    logic [ADDR_W-1:0] addr = '0;
    logic [DATA_W-1:0] wdata = '0;
    logic              wr = 0;
    logic              rd = 0;
    logic              tick = 0;
    logic [DATA_W-1:0] cur [6] = '{default: 8'h00};
    logic [DATA_W-1:0] rdata;
    logic              irq;
    logic              flag;
    logic              match;
    logic              rd_d = 0;
    logic [DATA_W-1:0] exp_q [$];
    int                fail_count = 0;
    int                tests_run = 0;
    // alarm offsets and readable bits per field
    logic [7:0] fa [6] = '{8'h10, 8'h11, 8'h12, 8'h13, 8'h14, 8'h16};
    logic [7:0] fm [6] = '{8'h7f, 8'h7f, 8'h3f, 8'h3f, 8'h07, 8'h7f};

    rtc_alarm_compare rtc_alarm_compare_inst (
        .MCLK(mclk), .ARST_N(arst_n), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
        .RDATA(rdata), .TICK(tick), .CUR_SECONDS(cur[0]), .CUR_MINUTES(cur[1]),
        .CUR_HOURS(cur[2]), .CUR_DAYS(cur[3]), .CUR_WEEKDAYS(cur[4]), .CUR_YEARS(cur[5]),
        .IRQ(irq), .ALARM_FLAG(flag), .MATCH(match)
    );

    // ****************************************
    // clock, tasks
    // ****************************************
    always #50 mclk = ~mclk;

    task chk(input string n, input logic [7:0] s, input logic [7:0] e);
        tests_run++;
        if (s !== e) begin
            fail_count++;
            $display("[ERR] %s expected %h seen %h", n, e, s);
        end
    endtask : chk

    task wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge mclk);
        wr    <= 1'b0;
    endtask : wr_reg

    // one read; the expected value waits in the queue for the watcher
    task rd_reg(input logic [7:0] a, input logic [7:0] e);
        @(posedge mclk);
        addr <= a;
        rd   <= 1'b1;
        exp_q.push_back(e);
        @(posedge mclk);
        rd   <= 1'b0;
    endtask : rd_reg

    // one update strobe, then let flag and interrupt settle
    task do_tick(input logic f, input logic i, input logic m);
        @(posedge mclk);
        tick <= 1'b1;
        @(posedge mclk);
        tick <= 1'b0;
        repeat (2) @(negedge mclk);
        chk("ALARM_FLAG", {7'h0, flag}, {7'h0, f});
        chk("IRQ", {7'h0, irq}, {7'h0, i});
        chk("MATCH", {7'h0, match}, {7'h0, m});
    endtask : do_tick

    task complete_run;
        $display("checks %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : complete_run

    // ****************************************
    // read data watcher
    // ****************************************
    always @(posedge mclk) begin
        rd_d <= rd;
    end
    always @(negedge mclk) begin
        if (rd_d) begin
            chk("RDATA", rdata, exp_q.pop_front());
        end
    end

    initial begin
        #2_000_000;
        fail_count++;
        complete_run();
    end

    // ****************************************
    // scenarios
    // ****************************************
    initial begin
        logic [7:0] d;
        logic [7:0] v;
        d = $urandom(32'h2ab32215);
        repeat (3) @(posedge mclk);
        arst_n <= 1'b1;
        // reset values, unmapped 0x15 included
        for (int i = 0; i < 7; i++) rd_reg(8'h10 + i, 8'h00);
        rd_reg(8'h01, 8'h00);
        rd_reg(8'h02, 8'h00);
        // random write and read back, unused bits read zero
        for (int i = 0; i < 7; i++) begin
            d = $urandom;
            wr_reg(8'h10 + i, d);
            rd_reg(8'h10 + i, (i == 5) ? 8'h00 : (i == 6) ? d : d & {1'b1, fm[i][6:0]});
        end
        // nothing enabled never matches; status is read-only
        for (int g = 0; g < 6; g++) wr_reg(fa[g], {1'b0, 7'($urandom)});
        wr_reg(8'h03, 8'hff);
        rd_reg(8'h03, 8'h00);
        wr_reg(8'h01, 8'h01);
        do_tick(0, 0, 0);
        // each field alone, others hold random disabled values
        for (int f = 0; f < 6; f++) begin
            v = 8'($urandom) & fm[f];
            for (int g = 0; g < 6; g++) begin
                wr_reg(fa[g], (g == f) ? {1'b1, v[6:0]} : {1'b0, 7'($urandom)});
                cur[g] <= 8'($urandom);
            end
            cur[f] <= (8'($urandom) & ~fm[f]) | v;
            do_tick(1, 1, 1);
            rd_reg(8'h03, 8'h03);
            wr_reg(8'h02, 8'h01);
            do_tick(0, 0, 1);
            cur[f] <= cur[f] ^ 8'h01;
            do_tick(0, 0, 0);
        end
        // seconds, minutes and year (still enabled from the loop) enabled: all three must agree
        wr_reg(fa[0], 8'h85);
        wr_reg(fa[1], 8'ha3);
        cur[0] <= 8'h05;
        cur[1] <= 8'h22;
        cur[5] <= cur[5] ^ 8'h01;
        do_tick(0, 0, 0);
        cur[1] <= 8'h23;
        do_tick(1, 1, 1);
        wr_reg(8'h01, 8'h00);
        repeat (2) @(negedge mclk);
        chk("IRQ", {7'h0, irq}, 8'h00);
        chk("ALARM_FLAG", {7'h0, flag}, 8'h01);
        // a rise with interrupts off is lost
        wr_reg(8'h02, 8'h01);
        cur[0] <= 8'h06;
        do_tick(0, 0, 0);
        cur[0] <= 8'h05;
        do_tick(0, 0, 1);
        rd_reg(8'h02, 8'h00);
        wr_reg(8'h01, 8'h01);
        repeat (3) @(negedge mclk);
        chk("IRQ", {7'h0, irq}, 8'h00);
        complete_run();
    end
endmodule : rtc_alarm_compare_bench
